// ---- cfg_pin_control.sv ----
// Configuration pin control: mode latch, tristate, readback, error flag
// Behaviour
// - During configuration a low request pin forces global I/O tristate.
// - After configuration an image option keeps tristate or allows readback.
// - With readback enabled, request falling edge starts readback at frame 0.
// - Readback data streams out on the shared serial output pin.
// - With boundary-scan active that pin carries test data output instead.
// - Configuration errors drive the shared interrupt pin low.
// - With host processor port used the pin is its interrupt request.
// - Mode pins are latched on the rising edge of wait-hold.
// - Mode pins get pull-ups during configuration, user I/O afterwards.
// - PLL clock pins tristated with pull-ups, freed unless PLL uses them.
// - Device holds wait-hold low while clearing; external low blocks start.
// - Done released high at completion; external low delays start-up.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_pin_cfg.svh"
module cfg_pin_control
    import cfg_pin_pkg::*;
(
    input  wire logic                  clock_in,
    input  wire logic                  nrst_in,
    input  wire logic                  clear_done_in,
    input  wire logic                  cfg_end_in,
    input  wire logic                  cfg_error_in,
    input  wire logic                  host_port_en_in,
    input  wire logic                  host_port_irq_n_in,
    input  wire logic                  opt_readback_in,
    input  wire logic                  opt_ts_after_in,
    input  wire logic                  scan_active_in,
    input  wire logic                  tdo_in,
    input  wire logic [`WORD_W-1:0]    rb_word_in,
    input  wire logic                  rd_cfg_n_in,
    input  wire logic                  init_n_in,
    input  wire logic                  done_in,
    input  wire logic [`MODE_W-1:0]    mode_pins_in,
    input  wire logic [`PLL_W-1:0]     pll_used_in,
    output logic                       init_n_out,
    output logic                       init_n_oe_out,
    output logic                       done_out,
    output logic                       done_oe_out,
    output logic                       global_io_tristate_out,
    output logic                       rd_data_out,
    output logic                       cfg_irq_n_out,
    output logic [`MODE_W-1:0]         mode_out,
    output logic                       mode_pullup_out,
    output logic                       mode_user_io_out,
    output logic                       pll_pullup_out,
    output logic [`PLL_W-1:0]          pll_user_io_out,
    output logic                       rb_busy_out,
    output logic [`FRAME_W-1:0]        rb_frame_out,
    output logic                       rb_word_req_out,
    output logic                       user_mode_out
);
    cfg_state_t state_q;
    cfg_state_t state_d;
    rb_if rb ();

    rb_edge u_edge (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .rb       (rb)
    );
    assign rb.pin_level = rd_cfg_n_in;

    logic init_prev_q;
    wire  init_rise = init_n_in & ~init_prev_q;
    wire  configuring = (state_q == ST_CONFIG) || (state_q == ST_STARTUP);
    wire  in_user = (state_q == ST_USER);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_POWERUP: begin
                if (clear_done_in) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // External low on wait-hold keeps us here
                if (init_rise) begin
                    state_d = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (cfg_end_in) begin
                    state_d = ST_STARTUP;
                end
            end
            ST_STARTUP: begin
                // Start-up waits while done is held low outside
                if (done_in) begin
                    state_d = ST_USER;
                end
            end
            ST_USER: begin
                state_d = ST_USER;
            end
            default: state_d = ST_POWERUP;
        endcase
    end

    // Readback shifter
    logic                  rb_busy_q;
    logic [`FRAME_W-1:0]   frame_q;
    logic [`WORD_W-1:0]    shift_q;
    logic [`BIT_CNT_W-1:0] bit_q;
    logic                  req_q;
    wire  rb_allowed = in_user & opt_readback_in & ~opt_ts_after_in;
    wire  rb_start   = rb_allowed & rb.fall_pulse & ~rb_busy_q;
    wire  word_end   = rb_busy_q & (bit_q == `BIT_CNT_LAST);

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rb_busy_q <= 1'b0;
            frame_q   <= `FRAME_START;
            shift_q   <= '0;
            bit_q     <= '0;
            req_q     <= 1'b0;
        end else if (rb_start) begin
            rb_busy_q <= 1'b1;
            frame_q   <= `FRAME_START;
            shift_q   <= rb_word_in;
            bit_q     <= '0;
            req_q     <= 1'b1;
        end else if (rb_busy_q) begin
            bit_q   <= bit_q + 1'b1;
            // Ask for a new word only when readback carries on past it
            req_q   <= word_end & ~rd_cfg_n_in;
            if (word_end) begin
                shift_q <= rb_word_in;
                frame_q <= frame_q + 1'b1;
            end else begin
                shift_q <= {shift_q[`WORD_W-2:0], 1'b0};
            end
            // Ending readback: host raises request again after the edge
            if (word_end && !rd_cfg_n_in) begin
                rb_busy_q <= 1'b1;
            end else if (word_end) begin
                rb_busy_q <= 1'b0;
            end
        end else begin
            req_q <= 1'b0;
        end
    end

    // Output stage, every output from a flop
    wire ts_d = (configuring & ~rd_cfg_n_in)
              | (in_user & opt_ts_after_in & ~rd_cfg_n_in);
    wire rd_d = scan_active_in ? tdo_in
              : (rb_busy_q & shift_q[`WORD_W-1]);
    wire irq_d = host_port_en_in ? host_port_irq_n_in
               : ~(configuring & cfg_error_in);
    wire [`PLL_W-1:0] pll_d = in_user ? ~pll_used_in : '0;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q                <= ST_POWERUP;
            init_prev_q            <= 1'b0;
            init_n_out             <= 1'b0;
            init_n_oe_out          <= 1'b1;
            done_out               <= 1'b0;
            done_oe_out            <= 1'b1;
            global_io_tristate_out <= 1'b1;
            rd_data_out            <= 1'b0;
            cfg_irq_n_out          <= 1'b1;
            mode_out               <= `MODE_RST;
            mode_pullup_out        <= 1'b1;
            mode_user_io_out       <= 1'b0;
            pll_pullup_out         <= 1'b1;
            pll_user_io_out        <= '0;
            rb_busy_out            <= 1'b0;
            rb_frame_out           <= `FRAME_START;
            rb_word_req_out        <= 1'b0;
            user_mode_out          <= 1'b0;
        end else begin
            state_q       <= state_d;
            init_prev_q   <= init_n_in;
            // Open drain: drive low only while clearing
            init_n_out    <= 1'b0;
            init_n_oe_out <= (state_q == ST_POWERUP);
            // Released, not driven, when done
            done_out      <= 1'b0;
            done_oe_out   <= ~(state_q == ST_STARTUP || in_user);
            global_io_tristate_out <= ts_d;
            rd_data_out   <= rd_d;
            cfg_irq_n_out <= irq_d;
            if (state_q == ST_WAIT && init_rise) begin
                mode_out <= mode_pins_in;
            end
            mode_pullup_out  <= ~in_user;
            mode_user_io_out <= in_user;
            pll_pullup_out   <= ~in_user;
            pll_user_io_out  <= pll_d;
            rb_busy_out      <= rb_busy_q;
            rb_frame_out     <= frame_q;
            rb_word_req_out  <= req_q;
            user_mode_out    <= in_user;
        end
    end

    AST_TS_CONFIG: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (configuring && !rd_cfg_n_in) |=> global_io_tristate_out)
        else $error("tristate missing during configuration");
    AST_TS_OPTION: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (in_user && !opt_ts_after_in) |=> !global_io_tristate_out)
        else $error("tristate without option after configuration");
    AST_RB_START: assert property (@(posedge clock_in) disable iff (!nrst_in)
        rb_start |=> (rb_busy_q && frame_q == `FRAME_START))
        else $error("readback did not start at frame zero");
    AST_RB_DATA: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (rb_busy_q && !scan_active_in) |=> rd_data_out == $past(shift_q[`WORD_W-1]))
        else $error("readback data not on serial pin");
    AST_TDO: assert property (@(posedge clock_in) disable iff (!nrst_in)
        scan_active_in |=> rd_data_out == $past(tdo_in))
        else $error("test data not on shared pin");
    AST_ERR_IRQ: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (!host_port_en_in && configuring && cfg_error_in) |=> !cfg_irq_n_out)
        else $error("error not flagged low");
    AST_HOST_IRQ: assert property (@(posedge clock_in) disable iff (!nrst_in)
        host_port_en_in |=> cfg_irq_n_out == $past(host_port_irq_n_in))
        else $error("host port interrupt not passed");
    AST_MODE: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (state_q == ST_WAIT && init_rise) |=> mode_out == $past(mode_pins_in))
        else $error("mode not latched at wait-hold rise");
    AST_PULLUP: assert property (@(posedge clock_in) disable iff (!nrst_in)
        ##1 (mode_pullup_out == !user_mode_out))
        else $error("mode pull-up wrong");
    AST_WAIT_HOLD: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (state_q == ST_WAIT && !init_n_in) |=> state_q == ST_WAIT)
        else $error("configuration started under held wait-hold");
    AST_DONE_HOLD: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (state_q == ST_STARTUP && !done_in) |=> state_q == ST_STARTUP)
        else $error("start-up ran with done held low");

    COV_CONFIG: cover property (@(posedge clock_in) disable iff (!nrst_in)
        state_q == ST_CONFIG ##[1:50] state_q == ST_USER);
    COV_READBACK: cover property (@(posedge clock_in) disable iff (!nrst_in)
        rb_start ##[1:40] word_end);
    COV_ERROR: cover property (@(posedge clock_in) disable iff (!nrst_in)
        configuring && cfg_error_in);
endmodule : cfg_pin_control
`default_nettype wire

// ---- cfg_pin_cfg.svh ----
// Constants for the configuration pin control block
`ifndef CFG_PIN_CFG_SVH
`define CFG_PIN_CFG_SVH
`define MODE_W          4
`define MODE_RST        4'hF
`define FRAME_W         16
`define FRAME_START     16'h0000
`define WORD_W          32
`define BIT_CNT_W       5
`define BIT_CNT_LAST    5'h1F
`define PLL_W           16
`endif

// ---- cfg_pin_pkg.sv ----
// Types for the configuration pin control block
package cfg_pin_pkg;
    typedef enum logic [2:0] {
        ST_POWERUP = 3'h0,
        ST_WAIT    = 3'h1,
        ST_CONFIG  = 3'h2,
        ST_STARTUP = 3'h3,
        ST_USER    = 3'h4
    } cfg_state_t;
endpackage : cfg_pin_pkg

// ---- rb_if.sv ----
// Readback request pin level and falling-edge pulse between the top and the edge unit
`timescale 1ns/1ps
`default_nettype none
interface rb_if;
    logic pin_level;
    logic fall_pulse;
    modport edge_side (input pin_level, output fall_pulse);
    modport top_side  (output pin_level, input fall_pulse);
endinterface : rb_if
`default_nettype wire

// ---- rb_edge.sv ----
// Readback request synchroniser and single falling-edge detector
`timescale 1ns/1ps
`default_nettype none
module rb_edge (
    input  wire logic   clock_in,
    input  wire logic   nrst_in,
    rb_if.edge_side     rb
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic fall_q;
    wire  fall_d = prev_q & ~sync2_q;

    // Resets high so the pulled-up pin gives no false edge
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q  <= 1'b1;
            fall_q  <= 1'b0;
        end else begin
            sync1_q <= rb.pin_level;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            fall_q  <= fall_d;
        end
    end
    assign rb.fall_pulse = fall_q;

    AST_ONE_PULSE: assert property (@(posedge clock_in) disable iff (!nrst_in)
        fall_q |=> !fall_q) else $error("edge pulse longer than one cycle");
endmodule : rb_edge
`default_nettype wire

// ---- cfg_host_model.sv ----
// Board controller model driving the configuration control pins
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
    input  wire logic clock_in,
    input  wire logic nrst_in,
    input  wire logic init_n_drv_in,
    input  wire logic init_n_oe_in,
    input  wire logic done_drv_in,
    input  wire logic done_oe_in,
    input  wire logic hold_init_in,
    input  wire logic hold_done_in,
    input  wire logic rb_req_in,
    output logic      init_n_out,
    output logic      done_out,
    output logic      rd_cfg_n_out
);
    logic released_q;
    // Both lines have pull-ups; either party may pull them low
    assign init_n_out = !(init_n_oe_in && !init_n_drv_in) && !hold_init_in;
    assign done_out   = !(done_oe_in && !done_drv_in) && !hold_done_in;
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            released_q   <= 1'b0;
            rd_cfg_n_out <= 1'b1;
        end else begin
            if (init_n_out)
                released_q <= 1'b1;
            // Request stays high until wait-hold has been seen high
            rd_cfg_n_out <= !(released_q && rb_req_in);
        end
    end
endmodule : cfg_host_model
`default_nettype wire

// ---- tb_config_pin_control.sv ----
// Self-checking bench for the configuration pin control block
`timescale 1ns/1ps
`default_nettype none
`include "cfg_pin_cfg.svh"
module tb_config_pin_control;
    logic clk = 0, nrst = 0, clr = 0, cend = 0, cerr = 0, hp_en = 0;
    logic hp_irq = 1, opt_rb = 0, opt_ts = 0, scan = 0, tdo = 0;
    logic hold_i = 1, hold_d = 1, req = 0, rd_n, init, done;
    logic [31:0] word = 32'hA5C3_0F96, got;
    logic [3:0] mode_pins = 4'hA;
    logic [15:0] pll_used = 16'h00F0;
    logic i_drv, i_oe, d_drv, d_oe, ts, rd, irq, mpu, muio, ppu, busy;
    logic wreq, umode;
    logic [3:0] mode;
    logic [15:0] puio, frame;
    logic [5:0] rows [5] = '{6'b111010, 6'b101101, 6'b010001,
                             6'b110111, 6'b001000};
    int bad_count = 0, n_compared = 0, n_req = 0;

    always #10 clk = ~clk;
    always @(posedge clk) if (wreq === 1'b1) n_req++;

    cfg_host_model host (.clock_in(clk), .nrst_in(nrst),
        .init_n_drv_in(i_drv), .init_n_oe_in(i_oe), .done_drv_in(d_drv),
        .done_oe_in(d_oe), .hold_init_in(hold_i), .hold_done_in(hold_d),
        .rb_req_in(req), .init_n_out(init), .done_out(done),
        .rd_cfg_n_out(rd_n));

    cfg_pin_control DUT (.clock_in(clk), .nrst_in(nrst),
        .clear_done_in(clr), .cfg_end_in(cend), .cfg_error_in(cerr),
        .host_port_en_in(hp_en), .host_port_irq_n_in(hp_irq),
        .opt_readback_in(opt_rb), .opt_ts_after_in(opt_ts),
        .scan_active_in(scan), .tdo_in(tdo), .rb_word_in(word),
        .rd_cfg_n_in(rd_n), .init_n_in(init), .done_in(done),
        .mode_pins_in(mode_pins), .pll_used_in(pll_used),
        .init_n_out(i_drv), .init_n_oe_out(i_oe), .done_out(d_drv),
        .done_oe_out(d_oe), .global_io_tristate_out(ts),
        .rd_data_out(rd), .cfg_irq_n_out(irq), .mode_out(mode),
        .mode_pullup_out(mpu), .mode_user_io_out(muio),
        .pll_pullup_out(ppu), .pll_user_io_out(puio),
        .rb_busy_out(busy), .rb_frame_out(frame),
        .rb_word_req_out(wreq), .user_mode_out(umode));

    task automatic check(input string name, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // Level outputs settle within the synchroniser and output stages
    task automatic settle;
        repeat (6) @(posedge clk);
        #1;
    endtask : settle

    initial begin
        #50000;
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1;
        @(posedge clk) clr <= 1;
        settle();
        check("init_oe", i_oe, 0);
        check("mode_blocked", mode, 4'hF);
        check("tristate_pwr", ts, 0);
        @(posedge clk) hold_i <= 0;
        settle();
        mode_pins <= 4'h3;
        check("mode", mode, 4'hA);
        check("mode_pullup", {mpu, ppu, muio}, 3'b110);
        @(posedge clk) req <= 1;
        settle();
        check("tristate_low", ts, 1);
        check("mode_kept", mode, 4'hA);
        @(posedge clk) begin req <= 0; cerr <= 1; end
        settle();
        check("tristate_high", ts, 0);
        check("cfg_irq", irq, 0);
        @(posedge clk) begin cerr <= 0; cend <= 1; end
        settle();
        check("done_wait", umode, 0);
        @(posedge clk) hold_d <= 0;
        settle();
        check("user", {umode, d_oe, muio, mpu, ppu}, 5'b10100);
        check("pll_io", puio, 16'(~pll_used));
        foreach (rows[i]) begin
            @(posedge clk) {scan, tdo, hp_en, hp_irq} <= rows[i][5:2];
            settle();
            check("rd_data", rd, rows[i][1]);
            check("irq_n", irq, rows[i][0]);
        end
        @(posedge clk) begin opt_ts <= 1; opt_rb <= 1; req <= 1; scan <= 0; end
        settle();
        check("ts_after", {ts, busy}, 2'b10);
        @(posedge clk) req <= 0;
        settle();
        @(posedge clk) opt_ts <= 0;
        @(posedge clk) req <= 1;
        // Sample off the edge so the first serial bit is not missed
        for (int k = 0; k < 12 && busy !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        req <= 0;
        check("rb_busy", busy, 1);
        check("rb_frame", frame, `FRAME_START);
        for (int b = 31; b >= 0; b--) begin
            got[b] = rd;
            @(posedge clk);
            #1;
        end
        check("rb_word", got, word);
        settle();
        check("rb_stop", {busy, 8'(n_req)}, 9'h001);
        @(posedge clk) nrst <= 0;
        #1;
        check("reset", {i_oe, d_oe, ts, irq, umode, busy}, 6'h3C);
        check("reset_mode", mode, `MODE_RST);
        give_verdict();
    end
endmodule : tb_config_pin_control
`default_nettype wire
